// *** logic/isv_pkg.sv ***
`default_nettype none
package isv_pkg;
  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] CtrlOffset  = 8'h00;
  localparam logic [7:0] Entry0Offset = 8'h04;
  localparam logic [7:0] Entry1Offset = 8'h08;
  localparam logic [7:0] StatusOffset = 8'h0C;
  // ==========================================================
  // field positions
  localparam int CtrlEnableBit  = 0;
  localparam int EntryMaskBit   = 8;
  localparam int EntryModeLsb   = 9;
  localparam int StatIllegalBit = 0;
  localparam int StatReservedBit = 1;
  localparam int StatLastVecLsb = 8;
  localparam int StatBusyBit    = 16;
  // ==========================================================
  // reset values
  localparam logic       CtrlEnableReset = 1'b0;
  localparam logic [7:0] EntryVecReset   = 8'h00;
  localparam logic       EntryMaskReset  = 1'b1;
  // ==========================================================
  // architectural vectors
  localparam logic [7:0] VecDivide    = 8'h00;
  localparam logic [7:0] VecDebug     = 8'h01;
  localparam logic [7:0] VecNmi       = 8'h02;
  localparam logic [7:0] VecBreak     = 8'h03;
  localparam logic [7:0] VecOverflow  = 8'h04;
  localparam logic [7:0] VecBound     = 8'h05;
  localparam logic [7:0] VecUndef     = 8'h06;
  localparam logic [7:0] VecFpuNa     = 8'h07;
  localparam logic [7:0] VecDouble    = 8'h08;
  localparam logic [7:0] VecTask      = 8'h0A;
  localparam logic [7:0] VecAbsent    = 8'h0B;
  localparam logic [7:0] VecStack     = 8'h0C;
  localparam logic [7:0] VecProtect   = 8'h0D;
  localparam logic [7:0] VecPage      = 8'h0E;
  localparam logic [7:0] VecMath      = 8'h10;
  localparam logic [7:0] VecAlign     = 8'h11;
  localparam logic [7:0] VecMachine   = 8'h12;
  localparam logic [7:0] VecVectorFp  = 8'h13;
  localparam logic [7:0] VecResvLo    = 8'h14;
  localparam logic [7:0] VecResvHi    = 8'h1F;
  localparam logic [7:0] VecCtrlMin   = 8'h10;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ISV_FAULT, ISV_TRAP, ISV_FAULT_TRAP, ISV_ABORT, ISV_MASKABLE_REQUEST_PIN
  } isv_class_t;
  typedef enum logic [4:0] {
    ISV_DIVIDE, ISV_DEBUG, ISV_BREAK, ISV_OVERFLOW, ISV_BOUND,
    ISV_UNDEF, ISV_FPU_NA, ISV_DOUBLE, ISV_TASK, ISV_ABSENT,
    ISV_STACK, ISV_PROTECT, ISV_PAGE, ISV_MATH, ISV_ALIGN,
    ISV_MACHINE, ISV_VECTOR_FP
  } isv_exc_t;
  typedef enum logic [1:0] {
    ISV_MODE_FIXED, ISV_MODE_NMI, ISV_MODE_EXTINT
  } isv_mode_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
    isv_class_t cls;
    logic       errPresent;
    logic       errZero;
    logic       nmi;
  } isv_dispatch_t;
  typedef struct packed {
    logic [7:0] vector;
    logic       mask;
    isv_mode_t  mode;
  } isv_entry_t;
endpackage : isv_pkg
`default_nettype wire

// *** logic/isv_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module isv_sync #(
  parameter int Width = 3
) (
  // clocking
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             clkEn,
  // pins in, level out
  input  wire logic [Width-1:0] asyncIn,
  output var  logic [Width-1:0] syncOut
);
  logic [Width-1:0] stage1;

  // ==========================================================
  // two-flop synchroniser per bit; stage1 feeds stage2 only
  for (genvar i = 0; i < Width; i++) begin : g_bit
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        stage1[i]  <= 1'b0;
        syncOut[i] <= 1'b0;
      end else if (clkEn) begin
        stage1[i]  <= asyncIn[i];
        syncOut[i] <= stage1[i];
      end
    end
  end
endmodule : isv_sync
`default_nettype wire

// *** logic/isv_vector_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module isv_vector_select #(
  parameter logic MachineErrCode = 1'b0
) (
  // clocking
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  clkEn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // pins (asynchronous)
  input  wire logic [1:0]            localIrqPins,
  input  wire logic                  hwDisablePin,
  // core side
  input  wire logic                  flagsIntEnable,
  input  wire logic                  excValid,
  input  wire isv_pkg::isv_exc_t     excKind,
  input  wire logic                  swIntValid,
  input  wire logic [7:0]            swIntVector,
  // external controller vector fetch
  output var  logic                  vecAck,
  input  wire logic                  extVecValid,
  input  wire logic [7:0]            extVector,
  // io controller and peer messages
  input  wire logic                  msgValid,
  input  wire logic [7:0]            msgVector,
  output var  logic                  msgReady,
  // dispatch
  output var  isv_pkg::isv_dispatch_t dispatch
);
  import isv_pkg::*;

  logic [1:0]    pinSync;
  logic          hwDisable;
  logic [1:0]    pinPrev;
  logic [1:0]    pinRise;
  logic          ctrlEnable;
  isv_entry_t    entry [2];
  logic          illegalFlag;
  logic          reservedFlag;
  logic [7:0]    lastVector;
  logic          fetchBusy;
  logic          nmiPend;
  logic [1:0]    fixedPend;
  logic          msgPend;
  logic [7:0]    msgHeld;
  logic          ctrlOn;
  logic          apbWrite;
  logic          apbSetup;
  logic          wantFetch;
  logic          lintExt;
  logic          lintNmi;
  logic          takeMsg;
  logic          takeFixed;
  logic          fixedSel;
  logic          takeNmi;
  logic          msgIllegal;
  logic          fixedIllegal;
  isv_dispatch_t next_dispatch;

  // ==========================================================
  // pin synchronisers
  isv_sync #(
    .Width(3)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clkEn    (clkEn),
    .asyncIn  ({hwDisablePin, localIrqPins}),
    .syncOut  ({hwDisable, pinSync})
  );

  // ==========================================================
  // decode helpers
  function automatic logic isReserved(input logic [7:0] v);
    isReserved = (v >= VecResvLo && v <= VecResvHi) || v == 8'h09 || v == 8'h0F;
  endfunction : isReserved

  function automatic logic ctrlIllegal(input logic [7:0] v);
    ctrlIllegal = v < VecCtrlMin;
  endfunction : ctrlIllegal

  // user interrupt descriptor, never carries an error code
  function automatic isv_dispatch_t userIrq(input logic [7:0] v, input logic n);
    userIrq = '{valid: 1'b1, vector: v, cls: ISV_MASKABLE_REQUEST_PIN,
                errPresent: 1'b0, errZero: 1'b0, nmi: n};
  endfunction : userIrq

  function automatic isv_dispatch_t excEntry(input isv_exc_t k);
    isv_dispatch_t d;
    d = '{valid: 1'b1, vector: VecDivide, cls: ISV_FAULT,
          errPresent: 1'b0, errZero: 1'b0, nmi: 1'b0};
    case (k)
      ISV_DIVIDE:    d.vector = VecDivide;
      ISV_DEBUG: begin
        d.vector = VecDebug;
        d.cls    = ISV_FAULT_TRAP;
      end
      ISV_BREAK: begin
        d.vector = VecBreak;
        d.cls    = ISV_TRAP;
      end
      ISV_OVERFLOW: begin
        d.vector = VecOverflow;
        d.cls    = ISV_TRAP;
      end
      ISV_BOUND:     d.vector = VecBound;
      ISV_UNDEF:     d.vector = VecUndef;
      ISV_FPU_NA:    d.vector = VecFpuNa;
      ISV_DOUBLE: begin
        d.vector     = VecDouble;
        d.cls        = ISV_ABORT;
        d.errPresent = 1'b1;
        d.errZero    = 1'b1;
      end
      // vector 9 has no kind and so can never be produced
      ISV_TASK, ISV_ABSENT, ISV_STACK, ISV_PROTECT, ISV_PAGE: begin
        d.errPresent = 1'b1;
        case (k)
          ISV_TASK:    d.vector = VecTask;
          ISV_ABSENT:  d.vector = VecAbsent;
          ISV_STACK:   d.vector = VecStack;
          ISV_PROTECT: d.vector = VecProtect;
          default:     d.vector = VecPage;
        endcase
      end
      ISV_MATH:      d.vector = VecMath;
      ISV_ALIGN: begin
        d.vector     = VecAlign;
        d.errPresent = 1'b1;
        d.errZero    = 1'b1;
      end
      ISV_MACHINE: begin
        d.vector     = VecMachine;
        d.cls        = ISV_ABORT;
        d.errPresent = MachineErrCode;
      end
      ISV_VECTOR_FP: d.vector = VecVectorFp;
      default:       d.valid = 1'b0;
    endcase
    excEntry = d;
  endfunction : excEntry

  // ==========================================================
  // mode and source qualification
  // hard disable overrides the software enable, as a strap would
  assign ctrlOn   = ctrlEnable && !hwDisable;
  assign pinRise  = pinSync & ~pinPrev;
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;
  // controller off: pin 0 is maskable request, pin 1 non-maskable
  assign lintExt = ctrlOn
                   ? ((pinSync[0] && !entry[0].mask && entry[0].mode == ISV_MODE_EXTINT)
                   || (pinSync[1] && !entry[1].mask && entry[1].mode == ISV_MODE_EXTINT))
                   : pinSync[0];
  assign lintNmi = ctrlOn
                   ? ((pinRise[0] && !entry[0].mask && entry[0].mode == ISV_MODE_NMI)
                   || (pinRise[1] && !entry[1].mask && entry[1].mode == ISV_MODE_NMI))
                   : pinRise[1];
  // all maskable hardware sources wait on the enable flag
  assign wantFetch   = lintExt && flagsIntEnable && !fetchBusy;
  assign fixedSel    = fixedPend[0] ? 1'b0 : 1'b1;
  assign msgIllegal  = ctrlIllegal(msgHeld);
  assign fixedIllegal = ctrlIllegal(entry[fixedSel].vector);
  assign takeNmi   = nmiPend && !excValid && !swIntValid;
  assign takeMsg   = msgPend && !takeNmi && !excValid && !swIntValid
                     && !extVecValid && flagsIntEnable;
  assign takeFixed = (|fixedPend) && !takeNmi && !msgPend && !excValid
                     && !swIntValid && !extVecValid && flagsIntEnable;

  // ==========================================================
  // dispatch selection: one event per cycle, fixed order
  // trade-off: core-driven events win outright, hardware ones wait
  always_comb begin
    next_dispatch = '0;
    if (excValid) begin
      next_dispatch = excEntry(excKind);
    end else if (swIntValid) begin
      next_dispatch = userIrq(swIntVector, 1'b0);
    end else if (takeNmi) begin
      next_dispatch = userIrq(VecNmi, 1'b1);
    end else if (extVecValid && fetchBusy) begin
      next_dispatch = userIrq(extVector, 1'b0);
    end else if (takeMsg && !msgIllegal) begin
      next_dispatch = userIrq(msgHeld, 1'b0);
    end else if (takeFixed && !fixedIllegal) begin
      next_dispatch = userIrq(entry[fixedSel].vector, 1'b0);
    end
  end

  // registered dispatch output
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dispatch <= '0;
    end else if (clkEn) begin
      dispatch <= next_dispatch;
    end
  end

  // ==========================================================
  // pin edge history
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinPrev <= 2'b00;
    end else if (clkEn) begin
      pinPrev <= pinSync;
    end
  end

  // ==========================================================
  // non-maskable edge latch, held until dispatched
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmiPend <= 1'b0;
    end else if (clkEn) begin
      if (lintNmi) begin
        nmiPend <= 1'b1;
      end else if (takeNmi) begin
        nmiPend <= 1'b0;
      end
    end
  end

  // ==========================================================
  // fixed-mode pin events, one pending bit per pin
  for (genvar p = 0; p < 2; p++) begin : g_fixed
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        fixedPend[p] <= 1'b0;
      end else if (clkEn) begin
        if (ctrlOn && pinRise[p] && !entry[p].mask
            && entry[p].mode == ISV_MODE_FIXED) begin
          fixedPend[p] <= 1'b1;
        end else if (takeFixed && fixedSel == 1'(p)) begin
          fixedPend[p] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // external controller fetch: ack pulse, then wait for vector
  // limitation: a second request is not seen until the vector returns
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vecAck    <= 1'b0;
      fetchBusy <= 1'b0;
    end else if (clkEn) begin
      vecAck <= wantFetch;
      if (wantFetch) begin
        fetchBusy <= 1'b1;
      end else if (extVecValid && fetchBusy && !excValid && !swIntValid && !takeNmi) begin
        fetchBusy <= 1'b0;
      end
    end
  end

  // ==========================================================
  // message intake from io controller or peers, one deep
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      msgPend  <= 1'b0;
      msgHeld  <= 8'h00;
      msgReady <= 1'b1;
    end else if (clkEn) begin
      if (msgValid && msgReady) begin
        msgPend  <= 1'b1;
        msgHeld  <= msgVector;
        msgReady <= 1'b0;
      end else if (takeMsg) begin
        msgPend  <= 1'b0;
        msgReady <= 1'b1;
      end
    end
  end

  // ==========================================================
  // status flags; hardware set wins over write-one-to-clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      illegalFlag  <= 1'b0;
      reservedFlag <= 1'b0;
      lastVector   <= 8'h00;
    end else if (clkEn) begin
      if ((takeMsg && msgIllegal) || (takeFixed && fixedIllegal)) begin
        illegalFlag <= 1'b1;
      end else if (apbWrite && paddr == StatusOffset && pwdata[StatIllegalBit]) begin
        illegalFlag <= 1'b0;
      end
      if (next_dispatch.valid && next_dispatch.cls == ISV_MASKABLE_REQUEST_PIN
          && isReserved(next_dispatch.vector) && !next_dispatch.nmi) begin
        reservedFlag <= 1'b1;
      end else if (apbWrite && paddr == StatusOffset && pwdata[StatReservedBit]) begin
        reservedFlag <= 1'b0;
      end
      if (next_dispatch.valid) begin
        lastVector <= next_dispatch.vector;
      end
    end
  end

  // ==========================================================
  // software-written control and local vector entries
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlEnable <= CtrlEnableReset;
      for (int e = 0; e < 2; e++) begin
        entry[e] <= '{vector: EntryVecReset, mask: EntryMaskReset, mode: ISV_MODE_FIXED};
      end
    end else if (clkEn && apbWrite) begin
      case (paddr)
        CtrlOffset:   ctrlEnable <= pwdata[CtrlEnableBit];
        Entry0Offset: entry[0] <= '{vector: pwdata[7:0], mask: pwdata[EntryMaskBit],
                                    mode: isv_mode_t'(pwdata[EntryModeLsb +: 2])};
        Entry1Offset: entry[1] <= '{vector: pwdata[7:0], mask: pwdata[EntryMaskBit],
                                    mode: isv_mode_t'(pwdata[EntryModeLsb +: 2])};
        default: ;
      endcase
    end
  end

  // ==========================================================
  // apb answer: no wait state, read data captured in setup
  // pin path events reach this block only through the status register, via illegalFlag, reservedFlag, lastVector and fetchBusy
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clkEn) begin
      pready  <= apbSetup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apbSetup) begin
        case (paddr)
          CtrlOffset:   prdata[CtrlEnableBit] <= ctrlEnable;
          Entry0Offset: prdata[10:0] <= {entry[0].mode, entry[0].mask, entry[0].vector};
          Entry1Offset: prdata[10:0] <= {entry[1].mode, entry[1].mask, entry[1].vector};
          StatusOffset: begin
            prdata[StatIllegalBit]         <= illegalFlag;
            prdata[StatReservedBit]        <= reservedFlag;
            prdata[StatLastVecLsb +: 8]    <= lastVector;
            prdata[StatBusyBit]            <= fetchBusy;
          end
          default:      pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : isv_vector_select
`default_nettype wire

// *** tb/isv_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module isv_checker
  import isv_pkg::*;
(
  // clocking
  input wire logic                   core_clk,
  input wire logic                   reset_n,
  input wire logic                   clkEn,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [7:0]             paddr,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // events
  input wire logic                   excValid,
  input wire isv_pkg::isv_exc_t      excKind,
  input wire logic                   swIntValid,
  input wire logic                   vecAck,
  input wire logic                   extVecValid,
  input wire logic [7:0]             extVector,
  input wire logic                   msgValid,
  input wire logic                   msgReady,
  input wire isv_pkg::isv_dispatch_t dispatch
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // answer seen while no exception or software interrupt claims the dispatch slot
  sequence s_answer;
    clkEn && extVecValid && !dispatch.valid && !excValid && !swIntValid;
  endsequence
  sequence s_setup;
    clkEn && psel && !penable;
  endsequence
  // ==========================================================
  // assertions
  a_setup_ready: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_unmapped_err: assert property (pready && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access not refused");
  a_divide_vec: assert property (clkEn && excValid && excKind == ISV_DIVIDE |=>
    dispatch.valid && dispatch.vector == 8'h00 && dispatch.cls == ISV_FAULT && !dispatch.errPresent)
    else $error("divide dispatch wrong");
  a_double_abort: assert property (clkEn && excValid && excKind == ISV_DOUBLE |=>
    dispatch.vector == 8'h08 && dispatch.cls == ISV_ABORT && dispatch.errPresent && dispatch.errZero)
    else $error("double fault dispatch wrong");
  a_errcode_faults: assert property (clkEn && excValid
    && excKind inside {ISV_TASK, ISV_ABSENT, ISV_STACK, ISV_PROTECT, ISV_PAGE} |=>
    dispatch.errPresent && dispatch.cls == ISV_FAULT && dispatch.vector inside {[8'h0A:8'h0E]})
    else $error("error code fault wrong");
  a_nmi_vector: assert property (dispatch.valid && dispatch.nmi |->
    dispatch.vector == 8'h02 && dispatch.cls == ISV_MASKABLE_REQUEST_PIN && !dispatch.errPresent)
    else $error("nmi dispatch wrong");
  a_vec9_never: assert property (dispatch.valid && dispatch.cls != ISV_MASKABLE_REQUEST_PIN |->
    dispatch.vector != 8'h09)
    else $error("vector 9 raised");
  a_ack_single: assert property (vecAck |=> !vecAck)
    else $error("fetch ask not a pulse");
  a_answer_used: assert property (s_answer |=> dispatch.valid
    && (dispatch.nmi || dispatch.vector == $past(extVector)))
    else $error("fetched vector not dispatched");
  a_msg_taken: assert property (clkEn && msgValid && msgReady |=> !msgReady)
    else $error("message slot not filled");
endmodule : isv_checker
bind isv_vector_select isv_checker isv_checker_inst (
  .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .excValid(excValid), .excKind(excKind),
  .swIntValid(swIntValid), .vecAck(vecAck), .extVecValid(extVecValid),
  .extVector(extVector), .msgValid(msgValid), .msgReady(msgReady), .dispatch(dispatch));
`default_nettype wire

// *** tb/isv_ext_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module isv_ext_ctrl (
  // clocking
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // fetch handshake
  input  wire logic       vecAck,
  input  wire logic       dispValid,
  input  wire logic [7:0] ansVec,
  output var  logic       extVecValid,
  output var  logic [7:0] extVector
);
  int   waitN;
  logic pend;
  // answer after a random stall and hold until dispatched; idle bus toggles so no stale match
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend        <= 1'b0;
      waitN       <= 0;
      extVecValid <= 1'b0;
      extVector   <= 8'h00;
    end else if (vecAck) begin
      pend      <= 1'b1;
      waitN     <= 4 + $urandom_range(0, 4);
      extVector <= ~extVector;
    end else if (extVecValid && dispValid) begin
      pend        <= 1'b0;
      extVecValid <= 1'b0;
      extVector   <= ~ansVec;
    end else if (pend && waitN == 0) begin
      extVecValid <= 1'b1;
      extVector   <= ansVec;
    end else begin
      waitN     <= waitN - 1;
      extVector <= ~extVector;
    end
  end
endmodule : isv_ext_ctrl
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module testbench;
  import isv_pkg::*;
  logic          core_clk, reset_n, clkEn, psel, penable, pwrite, pready, pslverr, hwDisablePin;
  logic          flagsIntEnable, excValid, swIntValid, vecAck, extVecValid, msgValid, msgReady;
  logic [7:0]    paddr, swIntVector, extVector, msgVector, ansVec;
  logic [31:0]   pwdata, prdata;
  logic [1:0]    localIrqPins;
  isv_exc_t      excKind;
  isv_dispatch_t dispatch;
  isv_dispatch_t dq [$];
  logic [31:0]   rq [$];
  logic [7:0]    vt [17] = '{0, 1, 3, 4, 5, 6, 7, 8, 10, 11, 12, 13, 14, 16, 17, 18, 19};
  int            n_errors, n_compared;
  isv_vector_select isv_vector_select_inst (.core_clk(core_clk), .reset_n(reset_n),
    .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .localIrqPins(localIrqPins), .hwDisablePin(hwDisablePin), .flagsIntEnable(flagsIntEnable),
    .excValid(excValid), .excKind(excKind), .swIntValid(swIntValid), .swIntVector(swIntVector),
    .vecAck(vecAck), .extVecValid(extVecValid), .extVector(extVector), .msgValid(msgValid),
    .msgVector(msgVector), .msgReady(msgReady), .dispatch(dispatch));
  isv_ext_ctrl isv_ext_ctrl_inst (.core_clk(core_clk), .reset_n(reset_n), .vecAck(vecAck),
    .dispValid(dispatch.valid), .ansVec(ansVec), .extVecValid(extVecValid),
    .extVector(extVector));
  // ==========================================================
  // clock, watchdog, result monitor
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  // results are taken oldest first; an unannounced dispatch is a mismatch too
  always @(posedge core_clk) begin
    if (dispatch.valid === 1'b1) begin
      if (dq.size() == 0) `CHK(dispatch.vector, 8'hxx)
      else `CHK(dispatch, dq.pop_front())
    end
    if (pready === 1'b1 && !pwrite && rq.size() > 0) `CHK(prdata, rq.pop_front())
  end
  // ==========================================================
  // tasks
  function automatic isv_dispatch_t ex(logic [7:0] v, isv_class_t c, logic p, logic z, logic n);
    return '{1'b1, v, c, p, z, n};
  endfunction : ex
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rq.push_back(d);
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1 && ++t < 50);
    `CHK(pready, 1'b1)
    `CHK(pslverr, e)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic waitq();
    int t;
    t = 0;
    while (dq.size() != 0 && t++ < 60) @(posedge core_clk);
    @(posedge core_clk);
    `CHK(dq.size(), 0)
  endtask : waitq
  task automatic pin(input int i, input isv_dispatch_t e);
    dq.push_back(e);
    localIrqPins[i] <= 1'b1;
    waitq();
    localIrqPins[i] <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : pin
  // maskable level on pin 0, then the far controller answers with a random vector
  task automatic fetch();
    int t;
    t = 0;
    ansVec <= 8'($urandom);
    localIrqPins[0] <= 1'b1;
    @(posedge core_clk);
    dq.push_back(ex(ansVec, ISV_MASKABLE_REQUEST_PIN, 0, 0, 0));
    do @(posedge core_clk); while (vecAck !== 1'b1 && ++t < 50);
    `CHK(vecAck, 1'b1)
    localIrqPins[0] <= 1'b0;
    waitq();
  endtask : fetch
  task automatic msg(input logic [7:0] v);
    int t;
    t = 0;
    msgValid <= 1'b1;
    msgVector <= v;
    do @(posedge core_clk); while (msgReady !== 1'b1 && ++t < 50);
    `CHK(msgReady, 1'b1)
    msgValid <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask : msg
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // ==========================================================
  // main sequence
  initial begin
    isv_exc_t   k;
    isv_class_t c;
    {reset_n, psel, penable, pwrite, hwDisablePin, flagsIntEnable, excValid} = '0;
    {swIntValid, msgValid, localIrqPins, paddr, pwdata, swIntVector, msgVector} = '0;
    excKind = ISV_DIVIDE;
    ansVec = 8'h00;
    clkEn = 1'b1;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    void'($urandom(32'he2fa));
    @(posedge core_clk);
    apb(0, CtrlOffset, 32'h0000_0000, 0);
    apb(0, Entry0Offset, 32'h0000_0100, 0);
    apb(0, StatusOffset, 32'h0000_0000, 0);
    apb(1, 8'h10, 32'h0000_0001, 1);
    $display("registers done");
    excValid <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      k = isv_exc_t'(i);
      c = (k inside {ISV_DOUBLE, ISV_MACHINE}) ? ISV_ABORT : (k == ISV_DEBUG) ? ISV_FAULT_TRAP
        : (k inside {ISV_BREAK, ISV_OVERFLOW}) ? ISV_TRAP : ISV_FAULT;
      dq.push_back(ex(vt[i], c, k inside {ISV_DOUBLE, ISV_TASK, ISV_ABSENT, ISV_STACK,
        ISV_PROTECT, ISV_PAGE, ISV_ALIGN}, k inside {ISV_DOUBLE, ISV_ALIGN}, 0));
      excKind <= k;
      @(posedge core_clk);
    end
    excValid <= 1'b0;
    waitq();
    // frozen clock enable: an exception offered now must never reach dispatch
    clkEn <= 1'b0;
    excValid <= 1'b1;
    repeat (3) @(posedge core_clk);
    clkEn <= 1'b1;
    excValid <= 1'b0;
    waitq();
    $display("exceptions done");
    pin(1, ex(VecNmi, ISV_MASKABLE_REQUEST_PIN, 0, 0, 1));
    localIrqPins[0] <= 1'b1;
    repeat (4) @(posedge core_clk);
    apb(0, StatusOffset, 32'h0000_0200, 0);
    flagsIntEnable <= 1'b1;
    fetch();
    $display("pins done");
    swIntValid <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      swIntVector <= (i == 8) ? 8'h14 : 8'($urandom_range(32, 255));
      @(posedge core_clk);
      dq.push_back(ex(swIntVector, ISV_MASKABLE_REQUEST_PIN, 0, 0, 0));
    end
    swIntValid <= 1'b0;
    waitq();
    apb(0, StatusOffset, 32'h0000_1402, 0);
    apb(1, StatusOffset, 32'h0000_0003, 0);
    apb(0, StatusOffset, 32'h0000_1400, 0);
    $display("software done");
    apb(1, CtrlOffset, 32'h0000_0001, 0);
    apb(0, CtrlOffset, 32'h0000_0001, 0);
    msg(8'h05);
    apb(0, StatusOffset, 32'h0000_1401, 0);
    dq.push_back(ex(8'h40, ISV_MASKABLE_REQUEST_PIN, 0, 0, 0));
    msg(8'h40);
    waitq();
    apb(1, Entry0Offset, 32'h0000_0055, 0);
    apb(1, Entry1Offset, 32'h0000_0200, 0);
    apb(0, Entry1Offset, 32'h0000_0200, 0);
    pin(0, ex(8'h55, ISV_MASKABLE_REQUEST_PIN, 0, 0, 0));
    pin(1, ex(VecNmi, ISV_MASKABLE_REQUEST_PIN, 0, 0, 1));
    apb(1, Entry0Offset, 32'h0000_0477, 0);
    fetch();
    hwDisablePin <= 1'b1;
    pin(1, ex(VecNmi, ISV_MASKABLE_REQUEST_PIN, 0, 0, 1));
    $display("controller done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
